// ---- rtl/dcr_pkg.sv ----
package dcr_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [6:0] DCR_ADDR_TEMP   = 7'h06;
	localparam logic [6:0] DCR_ADDR_MASK   = 7'h07;
	localparam logic [6:0] DCR_ADDR_OFS_A  = 7'h08;
	localparam logic [6:0] DCR_ADDR_OFS_B  = 7'h09;

	// ==========================================================
	// Field layout
	localparam int DCR_DATA_W          = 16;
	localparam int DCR_TEMP_LSB        = 8;
	localparam int DCR_TEMP_W          = 8;
	localparam int DCR_OFS_W           = 13;
	localparam int DCR_FIFO_OFS_LSB    = 13;
	localparam int DCR_FIFO_OFS_W      = 3;

	// ==========================================================
	// Mask bit positions
	localparam int DCR_MSK_ZEROCHK     = 15;
	localparam int DCR_MSK_COLLISION   = 13;
	localparam int DCR_MSK_ONE_AWAY    = 12;
	localparam int DCR_MSK_TWO_AWAY    = 11;
	localparam int DCR_MSK_CONV_CLK    = 10;
	localparam int DCR_MSK_DATA_CLK    = 9;
	localparam int DCR_MSK_OUT_FORCED  = 8;
	localparam int DCR_MSK_PATTERN     = 7;
	localparam int DCR_MSK_PLL         = 5;
	localparam int DCR_MSK_PARITY_A    = 4;
	localparam int DCR_MSK_PARITY_D    = 1;

	// ==========================================================
	// Reset values
	localparam logic [15:0] DCR_RST_MASK     = 16'hFFFF;
	localparam logic [12:0] DCR_RST_OFS      = 13'h0000;
	localparam logic [2:0]  DCR_RST_FIFO_OFS = 3'h4;
	localparam logic [15:0] DCR_RST_REG_B    = 16'h8000;
	localparam logic [7:0]  DCR_RST_TEMP     = 8'h00;

	// ==========================================================
	// Timing
	localparam int DCR_CLK_PERIOD_PS   = 4000;
	localparam int DCR_TEMP_SCLK_MIN_NS = 1000;
	localparam int DCR_TEMP_SCLK_MIN_CYC =
		(DCR_TEMP_SCLK_MIN_NS * 1000 + DCR_CLK_PERIOD_PS - 1) / DCR_CLK_PERIOD_PS;

endpackage : dcr_pkg

// ---- rtl/dcr_sync_if.sv ----
`timescale 1ns/1ps
interface dcr_sync_if;
	import dcr_pkg::*;

	logic                  load;
	logic [DCR_OFS_W-1:0]  staged_a;
	logic [DCR_OFS_W-1:0]  staged_b;
	logic [DCR_OFS_W-1:0]  applied_a;
	logic [DCR_OFS_W-1:0]  applied_b;

	modport ctrl
	(
		output load,
		output staged_a,
		output staged_b,
		input  applied_a,
		input  applied_b
	);

	modport apply
	(
		input  load,
		input  staged_a,
		input  staged_b,
		output applied_a,
		output applied_b
	);

endinterface : dcr_sync_if

// ---- rtl/dcr_offset_apply.sv ----
`timescale 1ns/1ps
module dcr_offset_apply
	import dcr_pkg::*;
(
	// Clock and reset
	input  wire logic   core_clk,
	input  wire logic   rst_n,
	input  wire logic   clk_en,
	// Staged and applied offsets
	dcr_sync_if.apply   sync
);

	// ==========================================================
	// Both channels load together on one auto-sync
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync.applied_a <= DCR_RST_OFS;
			sync.applied_b <= DCR_RST_OFS;
		end
		else if (clk_en && sync.load)
		begin
			sync.applied_a <= sync.staged_a;
			sync.applied_b <= sync.staged_b;
		end
	end

endmodule : dcr_offset_apply

// ---- rtl/dcr_config_regs.sv ----
`timescale 1ns/1ps
module dcr_config_regs
	import dcr_pkg::*;
#(
	parameter int ADDR_W = 7
)
(
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst_n,
	input  wire logic                      clk_en,
	// Register access
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	input  wire logic [ADDR_W-1:0]         reg_addr,
	input  wire logic [DCR_DATA_W-1:0]     reg_wdata,
	output logic      [DCR_DATA_W-1:0]     reg_rdata,
	output logic                           reg_rvalid,
	// Device status inputs
	input  wire logic [DCR_TEMP_W-1:0]     temp_sensor,
	input  wire logic                      auto_sync_enable,
	input  wire logic                      fifo_sync_req,
	// Datapath controls
	output logic      [DCR_DATA_W-1:0]     alarm_mask,
	output logic      [DCR_OFS_W-1:0]      channel_a_offset_applied,
	output logic      [DCR_OFS_W-1:0]      channel_b_offset_applied,
	output logic                           auto_sync_pulse,
	output logic                           fifo_ptr_load,
	output logic      [DCR_FIFO_OFS_W-1:0] fifo_ptr_value
);

	// ==========================================================
	// Elaboration check
	if (ADDR_W < 4)
	begin : g_addr_chk
		$error("ADDR_W too small for register map");
	end

	if (DCR_TEMP_LSB + DCR_TEMP_W != DCR_DATA_W)
	begin : g_temp_chk
		$error("Temperature byte must fill the top of the word");
	end

	if (DCR_FIFO_OFS_LSB != DCR_OFS_W)
	begin : g_fifo_chk
		$error("FIFO field must sit just above the channel B offset");
	end

	if (DCR_FIFO_OFS_LSB + DCR_FIFO_OFS_W != DCR_DATA_W)
	begin : g_word_chk
		$error("Channel B word must fill the data width");
	end

	if (DCR_RST_REG_B[DCR_FIFO_OFS_LSB +: DCR_FIFO_OFS_W] != DCR_RST_FIFO_OFS)
	begin : g_rst_chk
		$error("Channel B reset word disagrees with FIFO field reset");
	end

	// ==========================================================
	// Address decode
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [6:0] off);
		hit = (a == ADDR_W'(off));
	endfunction : hit

	logic wr_mask;
	logic wr_ofs_a;
	logic wr_ofs_b;

	assign wr_mask  = clk_en && reg_wr && hit(reg_addr, DCR_ADDR_MASK);
	assign wr_ofs_a = clk_en && reg_wr && hit(reg_addr, DCR_ADDR_OFS_A);
	assign wr_ofs_b = clk_en && reg_wr && hit(reg_addr, DCR_ADDR_OFS_B);

	// ==========================================================
	// Storage
	logic [DCR_TEMP_W-1:0]     temp_r;
	logic [DCR_DATA_W-1:0]     mask_r;
	logic [DCR_OFS_W-1:0]      channel_a_offset_value_r;
	logic [DCR_OFS_W-1:0]      channel_b_offset_value_r;
	logic [DCR_FIFO_OFS_W-1:0] fifo_ofs_r;

	// Temperature sampled continuously, never written by the host
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			temp_r <= DCR_RST_TEMP;
		else if (clk_en)
			temp_r <= temp_sensor;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			mask_r <= DCR_RST_MASK;
		else if (wr_mask)
			mask_r <= reg_wdata;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			channel_a_offset_value_r <= DCR_RST_OFS;
		else if (wr_ofs_a)
			channel_a_offset_value_r <= reg_wdata[DCR_OFS_W-1:0];
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			channel_b_offset_value_r <= DCR_RST_REG_B[DCR_OFS_W-1:0];
			fifo_ofs_r               <= DCR_RST_FIFO_OFS;
		end
		else if (wr_ofs_b)
		begin
			channel_b_offset_value_r <= reg_wdata[DCR_OFS_W-1:0];
			fifo_ofs_r <= reg_wdata[DCR_FIFO_OFS_LSB +: DCR_FIFO_OFS_W];
		end
	end

	// ==========================================================
	// Auto-sync: only a channel A write fires it
	logic sync_load_r;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			sync_load_r <= 1'b0;
		else if (clk_en)
			sync_load_r <= wr_ofs_a && auto_sync_enable;
	end

	dcr_sync_if sync_bus ();

	assign sync_bus.load     = sync_load_r && clk_en;
	assign sync_bus.staged_a = channel_a_offset_value_r;
	assign sync_bus.staged_b = channel_b_offset_value_r;

	dcr_offset_apply u_apply
	(
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.sync     (sync_bus.apply)
	);

	assign channel_a_offset_applied = sync_bus.applied_a;
	assign channel_b_offset_applied = sync_bus.applied_b;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			auto_sync_pulse <= 1'b0;
		else if (clk_en)
			auto_sync_pulse <= sync_load_r;
	end

	// ==========================================================
	// FIFO read pointer preload
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fifo_ptr_load  <= 1'b0;
			fifo_ptr_value <= DCR_RST_FIFO_OFS;
		end
		else if (clk_en)
		begin
			fifo_ptr_load <= fifo_sync_req;
			if (fifo_sync_req)
				fifo_ptr_value <= fifo_ofs_r;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			alarm_mask <= DCR_RST_MASK;
		else if (clk_en)
			alarm_mask <= mask_r;
	end

	// ==========================================================
	// Read path, unmapped reads return zero
	logic [DCR_DATA_W-1:0] rdata_nxt;

	always_comb
	begin
		rdata_nxt = '0;
		if (hit(reg_addr, DCR_ADDR_TEMP))
			rdata_nxt = {temp_r, 8'h00};
		else if (hit(reg_addr, DCR_ADDR_MASK))
			rdata_nxt = mask_r;
		else if (hit(reg_addr, DCR_ADDR_OFS_A))
			rdata_nxt = {3'h0, channel_a_offset_value_r};
		else if (hit(reg_addr, DCR_ADDR_OFS_B))
			rdata_nxt = {fifo_ofs_r, channel_b_offset_value_r};
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata  <= '0;
			reg_rvalid <= 1'b0;
		end
		else if (clk_en)
		begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= rdata_nxt;
		end
	end

endmodule : dcr_config_regs

// ---- tb/dcr_config_regs_assertions.sv ----
`timescale 1ns/1ps
module dcr_config_regs_assertions
	import dcr_pkg::*;
#(
	parameter int ADDR_W = 7
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic auto_sync_enable,
	input wire logic fifo_sync_req,
	input wire logic [15:0] alarm_mask,
	input wire logic [12:0] channel_b_offset_applied,
	input wire logic auto_sync_pulse,
	input wire logic fifo_ptr_load,
	input wire logic [2:0] fifo_ptr_value
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	sequence rd_take;
		clk_en && reg_rd;
	endsequence
	sequence wr_a_sync;
		clk_en && reg_wr && reg_addr == 7'h08 && auto_sync_enable;
	endsequence
	a_read_answer: assert property (rd_take |=> reg_rvalid) else $error("no answer");
	a_rvalid_cause: assert property (reg_rvalid && $past(clk_en) |-> $past(reg_rd))
		else $error("stray rvalid");
	a_temp_low: assert property (rd_take ##0 reg_addr == 7'h06 |=> reg_rdata[7:0] == 8'h00)
		else $error("temp low byte");
	a_mask_follow: assert property (clk_en && reg_wr && reg_addr == 7'h07
		|-> ##2 alarm_mask == $past(reg_wdata, 2)) else $error("mask copy");
	a_reset_vals: assert property ($rose(rst_n) |-> alarm_mask == 16'hFFFF
		&& fifo_ptr_value == 3'h4 && channel_b_offset_applied == 13'h0000) else $error("reset");
	a_sync_pulse: assert property (wr_a_sync |-> ##[2:4] auto_sync_pulse) else $error("sync");
	a_b_no_apply: assert property ($changed(channel_b_offset_applied)
		|-> ##[0:2] auto_sync_pulse) else $error("b applied");
	a_fifo_load: assert property (clk_en && fifo_sync_req |=> fifo_ptr_load) else $error("load");
	a_fifo_hold: assert property (!fifo_ptr_load |-> $stable(fifo_ptr_value))
		else $error("ptr moved");
endmodule : dcr_config_regs_assertions
bind dcr_config_regs dcr_config_regs_assertions #(.ADDR_W(ADDR_W)) u_chk (.core_clk, .rst_n,
	.clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .auto_sync_enable,
	.fifo_sync_req, .alarm_mask, .channel_b_offset_applied, .auto_sync_pulse, .fifo_ptr_load,
	.fifo_ptr_value);

// ---- tb/dcr_host_model.sv ----
`timescale 1ns/1ps
module dcr_host_model
	import dcr_pkg::*;
(
	input wire logic core_clk,
	input wire logic reg_rvalid,
	input wire logic [15:0] reg_rdata,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0,
	output logic [6:0] reg_addr = 7'h00,
	output logic [15:0] reg_wdata = 16'h0000
);
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		int i;
		if (a == DCR_ADDR_TEMP)
			repeat (DCR_TEMP_SCLK_MIN_CYC) @(negedge core_clk);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		for (i = 0; i < 3 && reg_rvalid !== 1'b1; i++)
			@(negedge core_clk);
		d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
	endtask : rd
	task automatic wr_pair(input logic [15:0] b, input logic [15:0] a);
		wr(DCR_ADDR_OFS_B, b);
		wr(DCR_ADDR_OFS_A, a);
	endtask : wr_pair
endmodule : dcr_host_model

// ---- tb/dcr_config_regs_tb.sv ----
`timescale 1ns/1ps
module dcr_config_regs_tb
	import dcr_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] temp_sensor = 8'hE7;
	logic auto_sync_enable = 1'b0;
	logic fifo_sync_req = 1'b0;
	logic reg_wr, reg_rd, reg_rvalid, auto_sync_pulse, fifo_ptr_load;
	logic [6:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, alarm_mask, d, a, b;
	logic [12:0] channel_a_offset_applied, channel_b_offset_applied, ea, eb;
	logic [2:0] fifo_ptr_value;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed = 32'h3e3d83e2;
	int i;
	always #2 core_clk = ~core_clk;
	dcr_config_regs u_dcr_config_regs (.core_clk, .rst_n, .clk_en, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_rvalid, .temp_sensor, .auto_sync_enable, .fifo_sync_req,
		.alarm_mask, .channel_a_offset_applied, .channel_b_offset_applied, .auto_sync_pulse,
		.fifo_ptr_load, .fifo_ptr_value);
	dcr_host_model u_dcr_host_model (.core_clk, .reg_rvalid, .reg_rdata, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata);
	function automatic logic [15:0] ofs(input logic [15:0] w);
		return {3'h0, w[12:0]};
	endfunction : ofs
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [6:0] ad, input logic [15:0] exp);
		u_dcr_host_model.rd(ad, d);
		chk(d, exp);
	endtask : rc
	task automatic report_and_stop();
		if (n_mismatch == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial
	begin
		ea = 13'h0000;
		eb = 13'h0000;
		repeat (4) @(negedge core_clk);
		rst_n = 1'b1;
		rc(DCR_ADDR_MASK, 16'hFFFF);
		rc(DCR_ADDR_OFS_A, 16'h0000);
		rc(DCR_ADDR_OFS_B, 16'h8000);
		rc(DCR_ADDR_TEMP, 16'hE700);
		u_dcr_host_model.wr(DCR_ADDR_TEMP, 16'h1234);
		temp_sensor = 8'($random(seed));
		rc(DCR_ADDR_TEMP, {temp_sensor, 8'h00});
		rc(7'h0A, 16'h0000);
		for (i = 0; i < 16; i++)
		begin
			u_dcr_host_model.wr(DCR_ADDR_MASK, 16'h0001 << i);
			rc(DCR_ADDR_MASK, 16'h0001 << i);
			chk(alarm_mask, 16'h0001 << i);
		end
		clk_en = 1'b0;
		u_dcr_host_model.wr(DCR_ADDR_MASK, 16'h0000);
		clk_en = 1'b1;
		rc(DCR_ADDR_MASK, 16'h8000);
		for (i = 0; i < 4; i++)
		begin
			b = 16'($random(seed));
			a = 16'($random(seed));
			auto_sync_enable = i[0];
			u_dcr_host_model.wr_pair(b, a);
			repeat (5) @(negedge core_clk);
			if (i[0])
			begin
				ea = a[12:0];
				eb = b[12:0];
			end
			chk({3'h0, channel_a_offset_applied}, {3'h0, ea});
			chk({3'h0, channel_b_offset_applied}, {3'h0, eb});
			rc(DCR_ADDR_OFS_A, ofs(a));
			u_dcr_host_model.wr(DCR_ADDR_OFS_B, ~b);
			repeat (5) @(negedge core_clk);
			chk({3'h0, channel_b_offset_applied}, {3'h0, eb});
			rc(DCR_ADDR_OFS_B, ~b);
			fifo_sync_req = 1'b1;
			@(negedge core_clk);
			fifo_sync_req = 1'b0;
			@(negedge core_clk);
			chk({13'h0, fifo_ptr_value}, {13'h0, ~b[15:13]});
		end
		report_and_stop();
	end
endmodule : dcr_config_regs_tb
